/* pfce_defs.svh */
// Purpose: timing counts, command codes and addresses for the flash host controller
// Assumes: 100 MHz CLOCK, 10 ns period
// Notes: command values sit in the low data byte only
`ifndef PFCE_DEFS_SVH
`define PFCE_DEFS_SVH

`define PFCE_CLK_NS 10
// strobe low time, kept well above the noise filter threshold
`define PFCE_FILTER_NS 15
`define PFCE_STROBE_NS 60
`define PFCE_STROBE_CYC ((`PFCE_STROBE_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
// read access allowance before sampling the data lines
`define PFCE_ACCESS_NS 90
`define PFCE_ACCESS_CYC ((`PFCE_ACCESS_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
// gap with all strobes high between two bus cycles
`define PFCE_GAP_NS 30
`define PFCE_GAP_CYC ((`PFCE_GAP_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)

`define PFCE_ADDR_UNLOCK1 15'h5555
`define PFCE_ADDR_UNLOCK2 15'h2aaa
`define PFCE_DATA_UNLOCK1 8'haa
`define PFCE_DATA_UNLOCK2 8'h55
`define PFCE_CMD_SETUP 8'h80
`define PFCE_CMD_CHIP_ERASE 8'h10
`define PFCE_CMD_MAIN_ERASE 8'h30
`define PFCE_CMD_PROGRAM 8'ha0
`define PFCE_CMD_LOCKOUT 8'h40
`define PFCE_CMD_ID_ENTRY 8'h90
`define PFCE_CMD_ID_EXIT 8'hf0
`define PFCE_ADDR_LOCK_STATUS 15'h0002
`define PFCE_BOOT_LAST 15'h1fff

`define PFCE_STEP_W 3
`define PFCE_CNT_W 8
`define PFCE_POLL_BIT 7
`define PFCE_TOGGLE_BIT 6
`define PFCE_LOCK_BIT 0

`endif

/* pfce_pkg.sv */
// Purpose: types shared by the flash host controller
// Assumes: pfce_defs.svh constants
// Notes: operation codes are the user-side order codes
package pfce_pkg;
   typedef enum logic [2:0] {
      OP_READ,
      OP_PROGRAM,
      OP_CHIP_ERASE,
      OP_MAIN_ERASE,
      OP_LOCKOUT,
      OP_ID_ENTRY,
      OP_ID_EXIT3,
      OP_ID_EXIT1
   } pfce_op_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_GAP,
      ST_POLL,
      ST_DONE
   } pfce_state_t;
endpackage

/* pfce_sync.sv */
// Purpose: three-stage synchroniser for the asynchronous data lines
// Assumes: a bit counts once stages two and three agree
// Notes: stage one feeds only stage two
module pfce_sync #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] stable;
   } pfce_sync_t;

   pfce_sync_t st_reg;
   pfce_sync_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.stable[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.stable;
endmodule

/* pfce_host.sv */
// Purpose: host controller driving a 32K x 16 parallel flash through its pins
// Assumes: one order at a time; device strobes are active low
// Notes: commands are emitted as whole sequences, then completion is polled for program, erase and lockout
module pfce_host #(
   parameter int POLL_LIMIT = 1000000
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // user order port
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire pfce_pkg::pfce_op_t REQ_OP,
   input wire logic [14:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   // user answer port
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA,
   output logic RSP_TIMEOUT,
   // flash pins
   output logic [14:0] WORD_ADDRESS_LINES,
   output logic CHIP_SELECT_N,
   output logic OUTPUT_ENABLE_N,
   output logic WRITE_STROBE_N,
   input wire logic [15:0] DATA_LINES_I,
   output logic [15:0] DATA_LINES_O,
   output logic DATA_LINES_OE
);
   `include "pfce_defs.svh"

   typedef struct packed {
      pfce_pkg::pfce_state_t state;
      pfce_pkg::pfce_op_t op;
      logic [`PFCE_STEP_W-1:0] step;
      logic [`PFCE_STEP_W-1:0] last;
      logic [`PFCE_CNT_W-1:0] cnt;
      logic [31:0] poll_cnt;
      logic is_read;
      logic busy_poll;
      logic [15:0] pdata;
      logic prev_toggle;
      logic have_prev;
      logic [14:0] addr;
      logic [15:0] wdata;
      logic [14:0] pin_addr;
      logic [15:0] pin_data;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic drive;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic rsp_timeout;
   } pfce_host_t;

   pfce_host_t st_reg;
   pfce_host_t st_next;
   logic [15:0] data_sync;

   pfce_sync #(
      .WIDTH(16)
   ) u_sync (
      .clk(CLOCK),
      .rst(RST),
      .din(DATA_LINES_I),
      .dout(data_sync)
   );

   // number of bus cycles for an order, minus one
   function automatic logic [`PFCE_STEP_W-1:0] seq_last(input pfce_pkg::pfce_op_t op);
      case (op)
         pfce_pkg::OP_READ: seq_last = 3'h0;
         pfce_pkg::OP_PROGRAM: seq_last = 3'h3;
         pfce_pkg::OP_ID_ENTRY: seq_last = 3'h2;
         pfce_pkg::OP_ID_EXIT3: seq_last = 3'h2;
         pfce_pkg::OP_ID_EXIT1: seq_last = 3'h0;
         default: seq_last = 3'h5;
      endcase
   endfunction

   // final command byte of the six-cycle orders
   function automatic logic [7:0] six_cmd(input pfce_pkg::pfce_op_t op);
      case (op)
         pfce_pkg::OP_CHIP_ERASE: six_cmd = `PFCE_CMD_CHIP_ERASE;
         pfce_pkg::OP_MAIN_ERASE: six_cmd = `PFCE_CMD_MAIN_ERASE;
         default: six_cmd = `PFCE_CMD_LOCKOUT;
      endcase
   endfunction

   // address and data for one bus cycle; upper byte sent as zero except in the program data cycle
   function automatic logic [30:0] cycle_word(input pfce_pkg::pfce_op_t op,
         input logic [`PFCE_STEP_W-1:0] step, input logic [14:0] a, input logic [15:0] d);
      logic [14:0] ca;
      logic [7:0] cd;
      ca = `PFCE_ADDR_UNLOCK1;
      cd = `PFCE_DATA_UNLOCK1;
      if (step == 3'h1 || step == 3'h4) begin
         ca = `PFCE_ADDR_UNLOCK2;
         cd = `PFCE_DATA_UNLOCK2;
      end else if (step == 3'h2) begin
         case (op)
            pfce_pkg::OP_PROGRAM: cd = `PFCE_CMD_PROGRAM;
            pfce_pkg::OP_ID_ENTRY: cd = `PFCE_CMD_ID_ENTRY;
            pfce_pkg::OP_ID_EXIT3: cd = `PFCE_CMD_ID_EXIT;
            default: cd = `PFCE_CMD_SETUP;
         endcase
      end else if (step == 3'h5) begin
         cd = six_cmd(op);
      end
      if (op == pfce_pkg::OP_ID_EXIT1) begin
         cd = `PFCE_CMD_ID_EXIT;
      end
      if (op == pfce_pkg::OP_PROGRAM && step == 3'h3) begin
         cycle_word = {a, d};
      end else begin
         cycle_word = {ca, 8'h00, cd};
      end
   endfunction

   always_comb begin
      logic [30:0] cw;
      logic toggling;
      logic done_ok;
      st_next = st_reg;
      cw = cycle_word(st_reg.op, st_reg.step, st_reg.addr, st_reg.wdata);
      toggling = 1'b0;
      done_ok = 1'b0;
      st_next.rsp_valid = 1'b0;
      case (st_reg.state)
         pfce_pkg::ST_IDLE: begin
            if (REQ_VALID) begin
               st_next.op = REQ_OP;
               st_next.addr = REQ_ADDR;
               st_next.wdata = REQ_WDATA;
               st_next.step = '0;
               st_next.last = seq_last(REQ_OP);
               st_next.is_read = (REQ_OP == pfce_pkg::OP_READ);
               st_next.busy_poll = (REQ_OP == pfce_pkg::OP_PROGRAM) ||
                  (REQ_OP == pfce_pkg::OP_CHIP_ERASE) || (REQ_OP == pfce_pkg::OP_MAIN_ERASE) ||
                  (REQ_OP == pfce_pkg::OP_LOCKOUT);
               st_next.have_prev = 1'b0;
               st_next.poll_cnt = '0;
               st_next.rsp_timeout = 1'b0;
               st_next.state = pfce_pkg::ST_SETUP;
            end
         end
         pfce_pkg::ST_SETUP: begin
            // address settles before any strobe falls
            st_next.cnt = '0;
            if (st_reg.is_read) begin
               st_next.pin_addr = st_reg.addr;
               st_next.drive = 1'b0;
            end else begin
               st_next.pin_addr = cw[30:16];
               st_next.pin_data = cw[15:0];
               st_next.oe_n = 1'b1;
               st_next.drive = 1'b1;
            end
            st_next.state = pfce_pkg::ST_STROBE;
         end
         pfce_pkg::ST_STROBE: begin
            st_next.cnt = st_reg.cnt + 8'h01;
            if (st_reg.cnt == '0) begin
               // strobes fall a cycle after the address, so no stale address is latched
               st_next.ce_n = 1'b0;
               st_next.oe_n = !st_reg.is_read;
               st_next.we_n = st_reg.is_read;
            end
            if (st_reg.is_read) begin
               if (st_reg.cnt == 8'(`PFCE_ACCESS_CYC)) begin
                  st_next.pdata = data_sync;
                  st_next.oe_n = 1'b1;
                  st_next.ce_n = 1'b1;
                  st_next.cnt = '0;
                  st_next.state = pfce_pkg::ST_GAP;
               end
            end else if (st_reg.cnt == 8'(`PFCE_STROBE_CYC)) begin
               // write strobe rises first so data holds past the capture
               st_next.we_n = 1'b1;
               st_next.cnt = '0;
               st_next.state = pfce_pkg::ST_GAP;
            end
         end
         pfce_pkg::ST_GAP: begin
            st_next.ce_n = 1'b1;
            st_next.cnt = st_reg.cnt + 8'h01;
            if (st_reg.cnt == 8'(`PFCE_GAP_CYC)) begin
               st_next.drive = 1'b0;
               st_next.cnt = '0;
               if (st_reg.is_read && !st_reg.busy_poll) begin
                  st_next.rsp_data = st_reg.pdata;
                  st_next.state = pfce_pkg::ST_DONE;
               end else if (st_reg.is_read) begin
                  st_next.state = pfce_pkg::ST_POLL;
               end else if (st_reg.step != st_reg.last) begin
                  st_next.step = st_reg.step + 3'h1;
                  st_next.state = pfce_pkg::ST_SETUP;
               end else if (st_reg.busy_poll) begin
                  // status reads from the last loaded word, or anywhere for erase
                  st_next.is_read = 1'b1;
                  st_next.state = pfce_pkg::ST_SETUP;
               end else begin
                  st_next.rsp_data = '0;
                  st_next.state = pfce_pkg::ST_DONE;
               end
            end
         end
         pfce_pkg::ST_POLL: begin
            // done when bit six stops toggling and, for a program, bit seven matches the written data
            toggling = st_reg.have_prev &&
               (st_reg.pdata[`PFCE_TOGGLE_BIT] != st_reg.prev_toggle);
            if (st_reg.op == pfce_pkg::OP_PROGRAM) begin
               done_ok = st_reg.have_prev && !toggling &&
                  (st_reg.pdata[`PFCE_POLL_BIT] == st_reg.wdata[`PFCE_POLL_BIT]);
            end else begin
               done_ok = st_reg.have_prev && !toggling;
            end
            st_next.prev_toggle = st_reg.pdata[`PFCE_TOGGLE_BIT];
            st_next.have_prev = 1'b1;
            st_next.poll_cnt = st_reg.poll_cnt + 32'h1;
            if (done_ok) begin
               st_next.rsp_data = st_reg.pdata;
               st_next.state = pfce_pkg::ST_DONE;
            end else if (st_reg.poll_cnt == 32'(POLL_LIMIT)) begin
               st_next.rsp_data = st_reg.pdata;
               st_next.rsp_timeout = 1'b1;
               st_next.state = pfce_pkg::ST_DONE;
            end else begin
               // no new write until done: device would drop it anyway
               st_next.state = pfce_pkg::ST_SETUP;
            end
         end
         pfce_pkg::ST_DONE: begin
            st_next.rsp_valid = 1'b1;
            st_next.state = pfce_pkg::ST_IDLE;
         end
         default: st_next.state = pfce_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_reg <= '0;
         st_reg.state <= pfce_pkg::ST_IDLE;
         st_reg.ce_n <= 1'b1;
         st_reg.oe_n <= 1'b1;
         st_reg.we_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign REQ_READY = (st_reg.state == pfce_pkg::ST_IDLE);
   assign RSP_VALID = st_reg.rsp_valid;
   assign RSP_RDATA = st_reg.rsp_data;
   assign RSP_TIMEOUT = st_reg.rsp_timeout;
   assign WORD_ADDRESS_LINES = st_reg.pin_addr;
   assign CHIP_SELECT_N = st_reg.ce_n;
   assign OUTPUT_ENABLE_N = st_reg.oe_n;
   assign WRITE_STROBE_N = st_reg.we_n;
   assign DATA_LINES_O = st_reg.pin_data;
   assign DATA_LINES_OE = st_reg.drive;
endmodule

/* pfce_host_monitor.sv */
// Purpose: pin and handshake checks on the flash host
// Assumes: one clock, synchronous active-high reset
// Notes: bound to pfce_host at the foot of this file
module pfce_host_monitor (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // user side
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   // flash pins
   input wire logic [14:0] WORD_ADDRESS_LINES,
   input wire logic CHIP_SELECT_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic [15:0] DATA_LINES_O,
   input wire logic DATA_LINES_OE
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   sequence we_pulse_s;
      (!WRITE_STROBE_N)[*6] ##1 WRITE_STROBE_N;
   endsequence
   sequence cs_after_s;
      !CHIP_SELECT_N ##1 CHIP_SELECT_N;
   endsequence
   no_contend_a: assert property (DATA_LINES_OE |-> OUTPUT_ENABLE_N)
      else $error("host drives data while output enable is low");
   write_inhibit_a: assert property (!WRITE_STROBE_N |-> OUTPUT_ENABLE_N && !CHIP_SELECT_N)
      else $error("write strobe low with a read or no select");
   strobe_width_a: assert property ($fell(WRITE_STROBE_N) |-> we_pulse_s)
      else $error("write strobe width wrong");
   cs_late_a: assert property ($rose(WRITE_STROBE_N) |-> cs_after_s)
      else $error("select must rise one cycle after write strobe");
   write_held_a: assert property (!WRITE_STROBE_N && $past(!WRITE_STROBE_N)
      |-> $stable(WORD_ADDRESS_LINES) && $stable(DATA_LINES_O) && DATA_LINES_OE)
      else $error("address or data moved during write");
   upper_zero_a: assert property ($fell(WRITE_STROBE_N)
      && WORD_ADDRESS_LINES inside {15'h5555, 15'h2aaa} |-> DATA_LINES_O[15:8] == 8'h00)
      else $error("command upper byte not zero");
   read_strobe_a: assert property ($fell(OUTPUT_ENABLE_N)
      |-> (!OUTPUT_ENABLE_N && !CHIP_SELECT_N && WRITE_STROBE_N)[*8])
      else $error("read strobes broken");
   ready_back_a: assert property (RSP_VALID |=> !RSP_VALID && REQ_READY)
      else $error("no new order accepted after answer");
endmodule

bind pfce_host pfce_host_monitor u_mon (
   .CLOCK(CLOCK), .RST(RST), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
   .WORD_ADDRESS_LINES(WORD_ADDRESS_LINES), .CHIP_SELECT_N(CHIP_SELECT_N),
   .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
   .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE(DATA_LINES_OE)
);

/* pfce_flash_model.sv */
// Purpose: behavioural flash device facing the host pins
// Assumes: active-low strobes, no clock
// Notes: busy times shortened; slow stretches them fourfold
module pfce_flash_model #(
   parameter logic [15:0] ID_MFR = 16'h00c3, // arbitrary value
   parameter logic [15:0] ID_DEV = 16'h0052, // arbitrary value
   parameter int PROG_NS = 800,
   parameter int ERASE_NS = 2000
) (
   // pins
   input wire logic [14:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [15:0] din,
   output logic [15:0] dout,
   // test control
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [32768];
   logic [15:0] rd, last;
   logic [14:0] a_lat;
   logic locked, id_mode, busy, tog, pb7, rd_on;
   realtime t_fall;
   int step;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      {locked, id_mode, busy, tog, pb7} = 5'h00;
      last = 16'h0000;
      step = 0;
      t_fall = 0.0;
   end
   task automatic run(input int ns);
      busy = 1'b1;
      fork
         begin
            #(slow ? 4 * ns : ns);
            busy = 1'b0;
         end
      join_none
   endtask
   task automatic erase(input logic all);
      for (int i = 0; i < 32768; i++)
         if (i > 'h1fff || (all && !locked)) mem[i] = 16'hffff;
      pb7 = 1'b1;
      run(ERASE_NS);
   endtask
   task automatic cmd(input logic [14:0] a, input logic [7:0] c);
      if (c == 8'hf0 && (step == 0 || (step == 2 && a == 15'h5555))) begin
         id_mode = 1'b0;
         step = 0;
      end else if (step == 6) begin
         if (!(locked && a <= 15'h1fff)) begin
            mem[a] = mem[a] & din;
            pb7 = din[7];
            run(PROG_NS);
         end
         step = 0;
      end else if (step == 0 || step == 3)
         step = (a == 15'h5555 && c == 8'haa) ? step + 1 : 0;
      else if (step == 1 || step == 4)
         step = (a == 15'h2aaa && c == 8'h55) ? step + 1 : 0;
      else if (a != 15'h5555)
         step = 0;
      else if (step == 2) begin
         step = (c == 8'h80) ? 3 : (c == 8'ha0) ? 6 : 0;
         if (c == 8'h90) id_mode = 1'b1;
      end else begin
         // back to array reads once the erase is launched
         step = 0;
         if (c == 8'h10 || c == 8'h30) erase(c == 8'h10);
         if (c == 8'h40) locked = 1'b1;
         if (c == 8'h40) run(PROG_NS);
      end
   endtask
   always @(negedge we_n or negedge ce_n)
      if (!we_n && !ce_n) begin
         t_fall = $realtime;
         a_lat = addr;
      end
   // data taken at whichever strobe rises first
   always @(posedge we_n or posedge ce_n)
      if ((ce_n ^ we_n) && oe_n && !busy && $realtime - t_fall >= 15.0)
         cmd(a_lat, din[7:0]);
   // one event per read start, whichever strobe falls last
   assign rd_on = !ce_n && !oe_n && we_n;
   always @(posedge rd_on)
      if (busy) tog = ~tog;
   always @* begin
      rd = mem[addr];
      if (id_mode) rd = (addr == 15'h0002) ? {15'h0, locked} : addr[0] ? ID_DEV : ID_MFR;
      if (busy) rd = {rd[15:8], ~pb7, tog, rd[5:0]};
   end
   // released bus shows the inverse of the last word, never a held value
   always @* if (!ce_n && !oe_n && we_n) last = rd;
   always @* dout = (!ce_n && !oe_n && we_n) ? rd : ~last;
endmodule

/* pfce_host_test.sv */
// Purpose: self-checking bench for the flash host
// Assumes: device model on the far side of the pins
// Notes: rows first, then locked boot and slow device cases
module pfce_host_test;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      pfce_pkg::pfce_op_t op;
      logic [14:0] a;
      logic [15:0] d;
      logic [15:0] r;
      logic chk;
   } pfce_row_t;
   localparam logic [15:0] MFR = 16'h00c3; // arbitrary value
   localparam int N = 25;
   logic clock, rst, req_valid, req_ready, rsp_valid, rsp_timeout;
   logic cs_n, oe_n, we_n, dq_oe, slow;
   pfce_pkg::pfce_op_t req_op;
   logic [14:0] req_addr, addr;
   logic [15:0] req_wdata, rsp_rdata, dq_o, dq_i, dev_q;
   int failures = 0;
   int checked = 0;
   pfce_row_t rows [N] = '{
      '{pfce_pkg::OP_PROGRAM, 15'h0100, 16'h1234, 16'h1234, 1},
      '{pfce_pkg::OP_READ, 15'h0100, 16'h0, 16'h1234, 1},
      '{pfce_pkg::OP_PROGRAM, 15'h0100, 16'hff0f, 16'h1204, 1},
      '{pfce_pkg::OP_PROGRAM, 15'h4000, 16'habcd, 16'habcd, 1},
      '{pfce_pkg::OP_ID_ENTRY, 15'h0, 16'h0, 16'h0, 1},
      '{pfce_pkg::OP_READ, 15'h0002, 16'h0, 16'h0000, 1},
      '{pfce_pkg::OP_READ, 15'h0000, 16'h0, MFR, 1},
      '{pfce_pkg::OP_ID_EXIT3, 15'h0, 16'h0, 16'h0, 1},
      '{pfce_pkg::OP_READ, 15'h0100, 16'h0, 16'h1204, 1},
      '{pfce_pkg::OP_ID_ENTRY, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_ID_EXIT1, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_MAIN_ERASE, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_READ, 15'h4000, 16'h0, 16'hffff, 1},
      '{pfce_pkg::OP_READ, 15'h0100, 16'h0, 16'h1204, 1},
      '{pfce_pkg::OP_CHIP_ERASE, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_READ, 15'h0100, 16'h0, 16'hffff, 1},
      '{pfce_pkg::OP_PROGRAM, 15'h0100, 16'h5a5a, 16'h5a5a, 1},
      '{pfce_pkg::OP_PROGRAM, 15'h4000, 16'h1111, 16'h1111, 1},
      '{pfce_pkg::OP_LOCKOUT, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_ID_ENTRY, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_READ, 15'h0002, 16'h0, 16'h0001, 1},
      '{pfce_pkg::OP_ID_EXIT1, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_CHIP_ERASE, 15'h0, 16'h0, 16'h0, 0},
      '{pfce_pkg::OP_READ, 15'h0100, 16'h0, 16'h5a5a, 1},
      '{pfce_pkg::OP_READ, 15'h4000, 16'h0, 16'hffff, 1}
   };
   pfce_host #(.POLL_LIMIT(20)) dut (
      .CLOCK(clock), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
      .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
      .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_TIMEOUT(rsp_timeout),
      .WORD_ADDRESS_LINES(addr), .CHIP_SELECT_N(cs_n), .OUTPUT_ENABLE_N(oe_n),
      .WRITE_STROBE_N(we_n), .DATA_LINES_I(dq_i), .DATA_LINES_O(dq_o),
      .DATA_LINES_OE(dq_oe)
   );
   pfce_flash_model #(.ID_MFR(MFR)) dev (
      .addr(addr), .ce_n(cs_n), .oe_n(oe_n), .we_n(we_n), .din(dq_i), .dout(dev_q),
      .slow(slow)
   );
   assign dq_i = dq_oe ? dq_o : dev_q;
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run_order(input pfce_pkg::pfce_op_t op, input logic [14:0] a,
                            input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clock);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      do @(posedge clock); while (req_ready !== 1'b1);
      @(negedge clock);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n == 5000) failures++;
      if (n == 5000) report_and_stop;
   endtask
   initial begin
      #200us;
      failures++;
      report_and_stop;
   end
   initial begin
      {rst, req_valid, slow} = 3'b100;
      req_op = pfce_pkg::OP_READ;
      req_addr = 15'h0;
      req_wdata = 16'h0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      check({12'h000, cs_n, oe_n, we_n, dq_oe}, 16'h000e);
      rst = 1'b0;
      $display("test reset done");
      for (int i = 0; i < N; i++) begin
         run_order(rows[i].op, rows[i].a, rows[i].d);
         check({15'h0, rsp_timeout}, 16'h0000);
         if (rows[i].chk) check(rsp_rdata, rows[i].r);
         $display("test row %0d done", i);
      end
      run_order(pfce_pkg::OP_PROGRAM, 15'h0200, 16'h0000);
      check({15'h0, rsp_timeout}, 16'h0001);
      run_order(pfce_pkg::OP_READ, 15'h0200, 16'h0);
      check(rsp_rdata, 16'hffff);
      $display("test locked boot done");
      // erase outlasts the poll limit, so the program lands while busy
      slow = 1'b1;
      run_order(pfce_pkg::OP_MAIN_ERASE, 15'h0, 16'h0);
      check({15'h0, rsp_timeout}, 16'h0001);
      run_order(pfce_pkg::OP_PROGRAM, 15'h4001, 16'h0000);
      check({15'h0, rsp_timeout}, 16'h0001);
      // let the stretched erase end before reading back
      repeat (600) @(negedge clock);
      run_order(pfce_pkg::OP_READ, 15'h4001, 16'h0);
      check(rsp_rdata, 16'hffff);
      $display("test slow device done");
      report_and_stop;
   end
endmodule
